// file: rtl/probe_break_trigger_control.sv
// Behaviour
// - Break-in modes rising, falling or off
// - Qualifying edge pulls debug-entry request low
// - Analyzer attached forces break-in rising
// - Unwired debug-entry: halt by scan, bounded wait
// - Trigger-out: monhigh, monlow, fixhigh, fixlow
// - Analyzer attached forces trigger-out monhigh
// - Unrestricted read while running: halt, read, resume
// - Restricted read while running returns error 647
// - Reset, break, step, run never restricted
// - Clock rate 512 kHz to 20 MHz, default 10
// - Unsupported rate falls to next lower rate; under 512 kHz gives 512 kHz
// - Rate value with K or M unit
// - Reading speed returns rate in use, unchanged
// - Clock independent of target clock
// - Threshold 1/2, 2/3 or 1/3 selectable
// - Reference target supply or internal mV/V level
// - Processor type saved to, restored from flash
// - Probe drives the clock setting link speed
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "probe_params.svh"
module probe_break_trigger_control #(
   parameter int halt_wait_cycles = `HALT_WAIT_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic break_in,
   input wire logic analyzer_attached,
   input wire logic target_in_monitor,
   input wire logic tdo,
   output logic tck,
   output logic tdi,
   output logic tms,
   output logic debug_entry_request_n,
   output logic debug_entry_request_n_en_n,
   output logic trigger_out,
   output logic [1:0] thresh_sel,
   output logic vref_internal,
   output logic [15:0] vref_mv,
   output logic flash_save,
   output logic [7:0] flash_wdata,
   input wire logic [7:0] flash_rdata
);
   import probe_pkg::*;

   typedef struct packed {
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [8:0] cfg;
      logic [5:0] div;
      logic [15:0] vref_mv;
      logic [7:0] proc;
      logic [9:0] err;
      logic halt_fail;
      logic [15:0] data;
      run_state_t state;
      cmd_t cmd;
      logic [7:0] sel;
      logic [7:0] op;
      logic brk_q;
      logic brk_pend;
      logic do_read;
      logic do_resume;
      logic ret_halt;
      logic halt_scanned;
      logic [23:0] cnt;
      logic [15:0] shift;
      logic [15:0] rx;
      logic [4:0] bits;
      logic tdi;
      logic tms;
      logic trig;
      logic de_drive;
      logic flash_save;
      logic [7:0] flash_wdata;
   } ctl_t;

   ctl_t s;
   ctl_t next_s;
   logic [3:0] sync_q;
   logic brk_s;
   logic ana_s;
   logic mon_s;
   logic tdo_s;
   logic brk_edge;
   breakin_t brk_mode;
   trig_t trig_mode;
   logic [32:0] rd;
   logic [31:0] wmask;
   logic [31:0] wd;
   logic start;
   logic [7:0] sop;

   tck_if t ();

   // ==========================================================
   // Pin synchronisers and clock divider
   sync_bits #(.W(4)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({tdo, target_in_monitor, analyzer_attached, break_in}),
      .q(sync_q)
   );
   assign brk_s = sync_q[0];
   assign ana_s = sync_q[1];
   assign mon_s = sync_q[2];
   assign tdo_s = sync_q[3];

   assign t.half_period = s.div;
   tck_gen u_tck (
      .aclk(aclk),
      .aresetn(aresetn),
      .t(t)
   );

   // ==========================================================
   // Helpers
   function automatic logic [5:0] speed_div(input logic [16:0] f);
      logic [31:0] khz;
      logic [31:0] n;
      khz = f[`UNIT_BIT] ? ({16'h0000, f[15:0]} * `KILO) : {16'h0000, f[15:0]};
      n = 32'h00000001;
      if (khz == 32'h00000000) begin
         n = {26'h0, `DIV_MAX};
      end else if (khz < `TCK_BASE_KHZ) begin
         n = (`TCK_BASE_KHZ + khz - 32'h00000001) / khz;
         if (n > {26'h0, `DIV_MAX}) begin
            n = {26'h0, `DIV_MAX};
         end
      end
      return n[5:0];
   endfunction : speed_div

   function automatic logic [32:0] reg_read(input ctl_t c, input logic [7:0] a,
                                            input logic an, input logic mo);
      logic [31:0] v;
      logic ok;
      logic [31:0] rate;
      v = 32'h00000000;
      ok = 1'b1;
      rate = `TCK_BASE_KHZ / {26'h0, c.div};
      case (a)
         `CFG_OFF: v = {23'h0, c.cfg};
         `SPEED_OFF: v = {10'h0, c.div, rate[15:0]};
         `VREF_OFF: v = {16'h0, c.vref_mv};
         `PROC_OFF: v = {24'h0, c.proc};
         `CMD_OFF: v = {16'h0, c.sel, 4'h0, c.cmd};
         `STATUS_OFF: v = {18'h0, c.halt_fail, an, mo, (c.state != ST_IDLE), c.err};
         `DATA_OFF: v = {16'h0, c.data};
         default: ok = 1'b0;
      endcase
      return {ok, v};
   endfunction : reg_read

   // ==========================================================
   // Next state
   always_comb begin
      next_s = s;
      next_s.flash_save = 1'b0;
      start = 1'b0;
      sop = `OP_HALT;
      rd = 33'h000000000;
      wd = 32'h00000000;
      wmask = {{8{s.w_strb[3]}}, {8{s.w_strb[2]}}, {8{s.w_strb[1]}}, {8{s.w_strb[0]}}};

      // Edge finder reads only the second synchroniser stage
      next_s.brk_q = brk_s;
      brk_mode = ana_s ? BRK_RISING : breakin_t'(s.cfg[1:0]);
      brk_edge = ((brk_mode == BRK_RISING) && brk_s && !s.brk_q) ||
                 ((brk_mode == BRK_FALLING) && !brk_s && s.brk_q);

      // AXI4-Lite write, address and data in either order
      if (awvalid && !s.aw_got) begin
         next_s.aw_got = 1'b1;
         next_s.aw_addr = awaddr;
      end
      if (wvalid && !s.w_got) begin
         next_s.w_got = 1'b1;
         next_s.w_data = wdata;
         next_s.w_strb = wstrb;
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s.aw_got && s.w_got && !s.bvalid) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         rd = reg_read(s, s.aw_addr, ana_s, mon_s);
         next_s.bresp = rd[32] ? 2'h0 : 2'h2;
         wd = (rd[31:0] & ~wmask) | (s.w_data & wmask);
         case (s.aw_addr)
            `CFG_OFF: next_s.cfg = wd[8:0];
            `SPEED_OFF: next_s.div = speed_div(s.w_data[16:0]);
            `VREF_OFF: next_s.vref_mv = s.w_data[`UNIT_BIT] ?
                  16'(s.w_data[15:0] * 16'h03E8) : s.w_data[15:0];
            `PROC_OFF: next_s.proc = wd[7:0];
            `CMD_OFF: begin
               // Commands arriving while busy are dropped
               if (s.state == ST_IDLE && s.cmd == CMD_NONE) begin
                  next_s.cmd = cmd_t'(s.w_data[3:0]);
                  next_s.sel = s.w_data[15:8];
               end
            end
            default: ;
         endcase
      end

      // AXI4-Lite read, one outstanding
      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
      if (arvalid && !s.rvalid) begin
         rd = reg_read(s, araddr, ana_s, mon_s);
         next_s.rvalid = 1'b1;
         next_s.rdata = rd[31:0];
         next_s.rresp = rd[32] ? 2'h0 : 2'h2;
      end

      // ==========================================================
      // Run control
      next_s.cnt = (s.state == ST_IDLE) ? 24'h000000 : s.cnt + 24'h000001;
      case (s.state)
         ST_IDLE: begin
            next_s.halt_scanned = 1'b0;
            next_s.ret_halt = 1'b0;
            if (s.brk_pend) begin
               next_s.brk_pend = 1'b0;
               if (!mon_s) begin
                  next_s.state = ST_HALT;
               end
            end else if (s.cmd != CMD_NONE) begin
               next_s.cmd = CMD_NONE;
               next_s.err = 10'h000;
               next_s.halt_fail = 1'b0;
               case (s.cmd)
                  CMD_BREAK: next_s.state = mon_s ? ST_IDLE : ST_HALT;
                  CMD_RUN: begin
                     start = 1'b1;
                     sop = `OP_RUN;
                  end
                  CMD_STEP: begin
                     start = 1'b1;
                     sop = `OP_STEP;
                  end
                  CMD_RESET: begin
                     start = 1'b1;
                     sop = `OP_RESET;
                  end
                  CMD_READ_REG, CMD_READ_MEM: begin
                     if (mon_s) begin
                        start = 1'b1;
                        sop = `OP_READ;
                     end else if (s.cfg[`CFG_RRT_BIT]) begin
                        next_s.err = `ERR_RESTRICTED;
                     end else begin
                        next_s.do_read = 1'b1;
                        next_s.do_resume = 1'b1;
                        next_s.state = ST_HALT;
                     end
                  end
                  CMD_SAVE: begin
                     next_s.flash_save = 1'b1;
                     next_s.flash_wdata = s.proc;
                  end
                  CMD_RESTORE: next_s.proc = flash_rdata;
                  default: ;
               endcase
            end
         end
         ST_HALT: begin
            if (!s.cfg[`CFG_DEW_BIT] && !s.halt_scanned) begin
               next_s.halt_scanned = 1'b1;
               next_s.ret_halt = 1'b1;
               start = 1'b1;
               sop = `OP_HALT;
            end else if (mon_s) begin
               if (s.do_read) begin
                  start = 1'b1;
                  sop = `OP_READ;
               end else begin
                  next_s.state = ST_IDLE;
               end
            end else if (s.cnt >= 24'(halt_wait_cycles - 1)) begin
               next_s.halt_fail = 1'b1;
               next_s.do_read = 1'b0;
               next_s.do_resume = 1'b0;
               next_s.state = ST_IDLE;
            end
         end
         ST_SCAN: begin
            if (t.rise && s.bits != 5'h00) begin
               next_s.rx = {tdo_s, s.rx[15:1]};
            end
            if (t.fall) begin
               if (s.bits == 5'h10) begin
                  next_s.tms = 1'b0;
                  if (s.ret_halt) begin
                     next_s.ret_halt = 1'b0;
                     next_s.state = ST_HALT;
                  end else if (s.op == `OP_READ) begin
                     next_s.data = s.rx;
                     next_s.do_read = 1'b0;
                     if (s.do_resume) begin
                        next_s.do_resume = 1'b0;
                        start = 1'b1;
                        sop = `OP_RUN;
                     end else begin
                        next_s.state = ST_IDLE;
                     end
                  end else begin
                     next_s.state = ST_IDLE;
                  end
               end else begin
                  next_s.tdi = s.shift[0];
                  next_s.shift = {1'b0, s.shift[15:1]};
                  next_s.tms = (s.bits == 5'h0F);
                  next_s.bits = s.bits + 5'h01;
               end
            end
         end
         default: next_s.state = ST_IDLE;
      endcase
      if (start) begin
         next_s.state = ST_SCAN;
         next_s.op = sop;
         next_s.shift = {sop, s.sel};
         next_s.bits = 5'h00;
      end
      // A break edge beside a clear of the pending flag still wins
      if (brk_edge) begin
         next_s.brk_pend = 1'b1;
      end
      next_s.de_drive = (next_s.state == ST_HALT);

      trig_mode = ana_s ? TRIG_MONHIGH : trig_t'(s.cfg[3:2]);
      case (trig_mode)
         TRIG_MONHIGH: next_s.trig = mon_s;
         TRIG_MONLOW: next_s.trig = ~mon_s;
         TRIG_FIXHIGH: next_s.trig = 1'b1;
         default: next_s.trig = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.cfg <= `CFG_RESET;
         s.div <= `DIV_RESET;
         s.vref_mv <= `VREF_RESET;
         s.proc <= `PROC_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Outputs
   assign awready = ~s.aw_got;
   assign wready = ~s.w_got;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = ~s.rvalid;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign tck = t.tck;
   assign tdi = s.tdi;
   assign tms = s.tms;
   // Open drain: pull low only; the target may pull too
   assign debug_entry_request_n = 1'b0;
   assign debug_entry_request_n_en_n = ~s.de_drive;
   assign trigger_out = s.trig;
   assign thresh_sel = s.cfg[7:6];
   assign vref_internal = s.cfg[`CFG_VINT_BIT];
   assign vref_mv = s.vref_mv;
   assign flash_save = s.flash_save;
   assign flash_wdata = s.flash_wdata;

   // ==========================================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   break_halt_a: assert property ((brk_edge && s.state == ST_IDLE && !s.brk_pend && !mon_s
      && s.cmd == CMD_NONE) |=> ##1 (s.state == ST_HALT || mon_s))
      else $error("break edge did not start a halt");
   de_drive_a: assert property ((s.state == ST_HALT) |-> !debug_entry_request_n_en_n)
      else $error("halt without debug entry drive");
   analyzer_rise_a: assert property ((ana_s && !brk_s && s.brk_q) |-> !brk_edge)
      else $error("falling edge accepted with analyzer attached");
   trig_mode_a: assert property (##1 (trigger_out == (($past(ana_s) ||
      $past(s.cfg[3:2]) == 2'h0) ? $past(mon_s) : ($past(s.cfg[3:2]) == 2'h1) ?
      !$past(mon_s) : ($past(s.cfg[3:2]) == 2'h2))))
      else $error("trigger out mode mismatch");
   rrt_refuse_a: assert property ((s.state == ST_IDLE && !s.brk_pend && !mon_s && s.cfg[4]
      && (s.cmd == CMD_READ_REG || s.cmd == CMD_READ_MEM)) |=> s.err == 10'h287)
      else $error("restricted read not refused");
   rrt_halt_a: assert property ((s.state == ST_IDLE && !s.brk_pend && !mon_s && !s.cfg[4]
      && s.cmd == CMD_READ_REG) |=> (s.state == ST_HALT && s.do_resume))
      else $error("unrestricted read did not halt");
   halt_bound_a: assert property ((s.state == ST_HALT) |-> (s.cnt < 24'(halt_wait_cycles)))
      else $error("halt wait overran");
   speed_round_a: assert property (s.bvalid && !$past(s.bvalid) && $past(s.aw_addr) == 8'h04
      |-> (s.div == 6'h27 || s.div == 6'h01 ||
      (32'h00004E20 / {26'h0, s.div}) <= ($past(s.w_data[16]) ?
      {16'h0, $past(s.w_data[15:0])} * 32'h3E8 : {16'h0, $past(s.w_data[15:0])})))
      else $error("speed not rounded down");
   speed_reset_a: assert property ($rose(aresetn) |-> s.div == 6'h02)
      else $error("speed default wrong");
endmodule : probe_break_trigger_control
`default_nettype wire

// file: rtl/probe_params.svh
`ifndef PROBE_PARAMS_SVH
`define PROBE_PARAMS_SVH

// ==========================================================
// Register offsets
`define CFG_OFF 8'h00
`define SPEED_OFF 8'h04
`define VREF_OFF 8'h08
`define PROC_OFF 8'h0C
`define CMD_OFF 8'h10
`define STATUS_OFF 8'h14
`define DATA_OFF 8'h18

// ==========================================================
// Field positions
`define CFG_BRK_LSB 0
`define CFG_TRIG_LSB 2
`define CFG_RRT_BIT 4
`define CFG_DEW_BIT 5
`define CFG_THR_LSB 6
`define CFG_VINT_BIT 8
`define UNIT_BIT 16
`define CMD_SEL_LSB 8
`define STAT_BUSY_BIT 10
`define STAT_MON_BIT 11
`define STAT_ANA_BIT 12
`define STAT_FAIL_BIT 13
`define SPEED_DIV_LSB 16

// ==========================================================
// Reset values
`define CFG_RESET 9'h020
`define DIV_RESET 6'h02
`define VREF_RESET 16'h0CE4
`define PROC_RESET 8'h01

// ==========================================================
// Rates, codes and timing
`define TCK_BASE_KHZ 32'h00004E20
`define DIV_MAX 6'h27
`define KILO 32'h000003E8
`define ERR_RESTRICTED 10'h287
`define OP_HALT 8'h01
`define OP_RUN 8'h02
`define OP_STEP 8'h03
`define OP_RESET 8'h04
`define OP_READ 8'h05
// Halt allowance, by line or by scan, 400 us, at 40 MHz
`define HALT_TIME_US 32'h00000190
`define CLK_MHZ 32'h00000028
`define HALT_WAIT_CYCLES (`HALT_TIME_US * `CLK_MHZ)

`endif

// file: rtl/probe_pkg.sv
package probe_pkg;
   typedef enum logic [1:0] {BRK_RISING, BRK_FALLING, BRK_OFF} breakin_t;
   typedef enum logic [1:0] {TRIG_MONHIGH, TRIG_MONLOW, TRIG_FIXHIGH, TRIG_FIXLOW} trig_t;
   typedef enum logic [3:0] {CMD_NONE, CMD_RESET, CMD_BREAK, CMD_STEP, CMD_RUN,
      CMD_READ_REG, CMD_READ_MEM, CMD_SAVE, CMD_RESTORE} cmd_t;
   typedef enum logic [1:0] {ST_IDLE, ST_HALT, ST_SCAN} run_state_t;
endpackage : probe_pkg

// file: rtl/sync_bits.sv
`timescale 1ns/1ps
`default_nettype none
module sync_bits #(parameter int W = 1) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } sync_state_t;
   sync_state_t s;
   sync_state_t next_s;

   always_comb begin
      next_s.meta = d;
      next_s.q = s.meta;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q = s.q;
endmodule : sync_bits
`default_nettype wire

// file: rtl/tck_gen.sv
`timescale 1ns/1ps
`default_nettype none
module tck_gen (
   input wire logic aclk,
   input wire logic aresetn,
   tck_if.gen t
);
   typedef struct packed {
      logic [5:0] cnt;
      logic tck;
   } tck_state_t;
   tck_state_t s;
   tck_state_t next_s;
   logic wrap;

   // ==========================================================
   // Free divider of the probe clock, target clock plays no part
   assign wrap = (s.cnt >= t.half_period - 6'h01);

   always_comb begin
      next_s = s;
      next_s.cnt = wrap ? 6'h00 : s.cnt + 6'h01;
      if (wrap) begin
         next_s.tck = ~s.tck;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign t.tck = s.tck;
   assign t.rise = wrap & ~s.tck;
   assign t.fall = wrap & s.tck;
endmodule : tck_gen
`default_nettype wire

// file: rtl/tck_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tck_if;
   logic [5:0] half_period;
   logic tck;
   logic rise;
   logic fall;
   modport gen (input half_period, output tck, output rise, output fall);
   modport user (output half_period, input tck, input rise, input fall);
endinterface : tck_if
`default_nettype wire

// file: verification/target_model.sv
`timescale 1ns/1ps
`default_nettype none
module target_model (
   input wire logic aclk,
   input wire logic tck,
   input wire logic tdi,
   input wire logic tms,
   input wire logic line_n,
   input wire logic wired,
   input wire logic [3:0] lag,
   output logic in_mon,
   output logic tdo
);
   logic [15:0] sh;
   logic [7:0] lf;
   logic [3:0] n;
   logic tk;
   initial begin
      in_mon = 1'h0;
      tdo = 1'h0;
      sh = 16'h0000;
      lf = 8'hA5;
      n = 4'h0;
      tk = 1'h0;
   end
   // ==========
   // Halt by line or by scan
   always @(posedge aclk) begin
      // Line only counts when wired; lag makes slow halts
      n = (wired && !line_n && n != 4'hF) ? n + 4'h1 : 4'h0;
      if (n != 4'h0 && n >= lag) in_mon <= 1'h1;
      // Never idle: a changing pattern so nothing is read by luck
      lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      tdo <= lf[0];
      if (tck && !tk) begin
         sh = {tdi, sh[15:1]};
         if (tms && sh[15:8] != 8'h00 && sh[15:8] <= 8'h03) in_mon <= sh[15:8] != 8'h02;
         if (tms && sh[15:8] == 8'h04) in_mon <= 1'h0;
      end
      tk = tck;
   end
endmodule : target_model
`default_nettype wire

// file: verification/tb_probe_break_trigger_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_probe_break_trigger_control;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, flash_rdata = 8'h00;
   logic [2:0] awprot = 3'h0, arprot = 3'h0;
   logic [3:0] wstrb = 4'hF, lag = 4'h2;
   logic [31:0] wdata = 32'h0, cfg = 32'h20, st, rdata;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic break_in = 1'h0, analyzer_attached = 1'h0, en_d = 1'h1;
   logic awready, wready, bvalid, arready, rvalid, tck, tdi, tms, trigger_out, flash_save;
   logic target_in_monitor, tdo, debug_entry_request_n, debug_entry_request_n_en_n;
   logic vref_internal, line_n;
   logic [1:0] bresp, rresp, resp, thresh_sel;
   logic [15:0] vref_mv;
   logic [7:0] flash_wdata, saved;
   int errors = 0, num_checks = 0, cyc = 0, pulls = 0;
   integer seed = 32'hD2D4E0E7;
   localparam logic [31:0] rst_tab [4] = '{32'h20, 32'h22710, 32'hCE4, 32'h1};
   always #12.5 aclk = ~aclk;
   // Released line floats up through the pull-up
   assign line_n = debug_entry_request_n_en_n ? 1'h1 : debug_entry_request_n;
   probe_break_trigger_control #(.halt_wait_cycles(200)) u_probe_break_trigger_control (
      .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .break_in, .analyzer_attached, .target_in_monitor, .tdo,
      .tck, .tdi, .tms, .debug_entry_request_n, .debug_entry_request_n_en_n, .trigger_out,
      .thresh_sel, .vref_internal, .vref_mv, .flash_save, .flash_wdata, .flash_rdata);
   target_model u_target_model (.aclk, .tck, .tdi, .tms, .line_n, .wired(cfg[5]), .lag,
      .in_mon(target_in_monitor), .tdo);
   // ==========
   // Shared tasks
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      en_d <= debug_entry_request_n_en_n;
      if (en_d && !debug_entry_request_n_en_n) pulls <= pulls + 1;
      if (flash_save) saved <= flash_wdata;
      if (cyc == 60000) begin
         errors++;
         final_report();
      end
   end
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         errors++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, gb;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(negedge aclk);
         ta = awready & awvalid;
         tw = wready & wvalid;
         gb = bvalid;
         resp = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
      end while (!gb);
      bready <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic ta, gr;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(negedge aclk);
         ta = arready & arvalid;
         gr = rvalid;
         d = rdata;
         resp = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'h0;
      end while (!gr);
      rready <= 1'h0;
   endtask : rd
   // Busy polled; commands sent while busy would be dropped
   task automatic cmd(input logic [3:0] c);
      wr(8'h10, {28'h0, c});
      do rd(8'h14, st); while (st[10] !== 1'h0);
   endtask : cmd
   task automatic setcfg(input logic [31:0] c);
      cfg <= c;
      wr(8'h00, c);
   endtask : setcfg
   function automatic int div_for(int k);
      if (k >= 20000) return 1;
      if (k < 513) return 39;
      return (20000 + k - 1) / k;
   endfunction : div_for
   // ==========
   // Main sequence
   initial begin : main
      logic [31:0] v, e, x;
      int k, n, m;
      real t;
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      for (k = 0; k < 4; k++) begin
         rd(8'(k * 4), v);
         chk("reset value", v, rst_tab[k]);
      end
      chk("reset pins", {thresh_sel, vref_internal}, 32'h0);
      rd(8'h1C, v);
      chk("unmapped rd", {resp, v[29:0]}, 32'h80000000);
      wr(8'h1C, 32'h5);
      chk("unmapped wr", resp, 32'h2);
      for (k = 0; k < 8; k++) begin
         m = k % 2;
         n = m ? 1 + {$random(seed)} % 25 : 300 + {$random(seed)} % 19000;
         if (k == 0) n = 512;
         wr(8'h04, {15'h0, m[0], n[15:0]});
         if (m) n = n * 1000;
         x = {10'h0, 6'(div_for(n)), 16'(20000 / div_for(n))};
         rd(8'h04, v);
         rd(8'h04, e);
         chk("speed", v, x);
         chk("speed query", e, x);
         @(posedge tck);
         t = $realtime;
         @(posedge tck);
         chk("tck period", 32'(int'(($realtime - t) / 25.0)), 32'(2 * div_for(n)));
      end
      wr(8'h04, 32'h1000A);
      rd(8'h04, v);
      chk("speed M", v, 32'h22710);
      for (k = 0; k < 3; k++) begin
         setcfg(32'h20 | (k << 6) | ((k % 2) << 8));
         repeat (3) @(posedge aclk);
         chk("thresh", {thresh_sel, vref_internal}, 32'(k * 2 + k % 2));
      end
      v = {$random(seed)} % 32768;
      wr(8'h08, v);
      rd(8'h08, e);
      chk("vref mv", {vref_mv, e[15:0]}, {v[15:0], v[15:0]});
      wr(8'h08, 32'h10003);
      rd(8'h08, e);
      chk("vref v", {vref_mv, e[15:0]}, 32'h0BB80BB8);
      for (k = 0; k < 16; k++) begin
         setcfg(32'h20 | ((k % 4) << 2));
         analyzer_attached <= k > 7;
         cmd(k[2] ? 4'h2 : 4'h4);
         repeat (6) @(posedge aclk);
         @(negedge aclk);
         m = k > 7 ? 0 : k % 4;
         chk("trigger", trigger_out, m > 1 ? m == 2 : target_in_monitor ^ m[0]);
         chk("trigger forced", st[12], k > 7);
      end
      // Last pass left the target halted; a halted target ignores breaks
      cmd(4'h4);
      for (k = 0; k < 6; k++) begin
         setcfg(32'h20 | (k % 3));
         analyzer_attached <= k > 2;
         lag <= 4'($random(seed));
         n = pulls;
         break_in <= 1'h1;
         repeat (40) @(posedge aclk);
         m = k > 2 ? 0 : k % 3;
         chk("break rise", pulls - n, m == 0);
         cmd(4'h4);
         break_in <= 1'h0;
         repeat (40) @(posedge aclk);
         chk("break total", pulls - n, m < 2);
         cmd(4'h4);
      end
      setcfg(32'h30);
      for (k = 5; k < 7; k++) begin
         cmd(4'(k));
         chk("restricted", {target_in_monitor, st[9:0]}, 32'h287);
      end
      for (k = 1; k < 5; k++) begin
         cmd(4'(k));
         chk("allowed", st[9:0], 32'h0);
      end
      setcfg(32'h20);
      n = pulls;
      cmd(4'h5);
      chk("read halts", pulls - n, 32'h1);
      chk("read resumes", {target_in_monitor, st[9:0]}, 32'h0);
      setcfg(32'h00);
      cmd(4'h2);
      chk("scan halt", {target_in_monitor, st[13]}, 32'h2);
      cmd(4'h4);
      // Line claimed wired but left open at the target: halt must time out
      wr(8'h00, 32'h20);
      cmd(4'h2);
      chk("halt timeout", {target_in_monitor, st[13]}, 32'h1);
      v = {$random(seed)} % 256;
      wr(8'h0C, v);
      cmd(4'h7);
      chk("save", saved, v);
      flash_rdata <= ~v[7:0];
      wr(8'h0C, 32'h0);
      cmd(4'h8);
      rd(8'h0C, e);
      chk("restore", e, {24'h0, ~v[7:0]});
      final_report();
   end
endmodule : tb_probe_break_trigger_control
`default_nettype wire
